// ==== verilog/ibt_defs.vh ====
// Constants shared by the two-wire bit-timing generator files
`ifndef IBT_DEFS_VH
`define IBT_DEFS_VH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define IBT_CODE_W 6
`define IBT_DIV_W 16
`define IBT_RATE_W 6
`define IBT_CNT_W 16
`define IBT_CMD_W 3
`define IBT_ST_W 3

// ----------------------------------------------------------------
// Timing figures, in local memory clock cycles, except the clock period in ns and the halving step count
// ----------------------------------------------------------------
`define IBT_CLK_PERIOD_NS 50
`define IBT_STOP_SETUP_CLKS 16'h0004
`define IBT_START_LIMIT_LO 16'h0010
`define IBT_START_LIMIT_HI 16'h0009
`define IBT_HOLD_BASE 16'h0008
`define IBT_HOLD_STEP 16'h0010
`define IBT_HALVE_STEPS 12

// ----------------------------------------------------------------
// Divider code fields
// ----------------------------------------------------------------
`define IBT_CODE_BANK 5
`define IBT_CODE_EXP_HI 4
`define IBT_CODE_EXP_LO 2
`define IBT_CODE_SEL 1

// ----------------------------------------------------------------
// Commands
// ----------------------------------------------------------------
`define IBT_CMD_START 3'h0
`define IBT_CMD_WRITE 3'h1
`define IBT_CMD_READ 3'h2
`define IBT_CMD_RSTART 3'h3
`define IBT_CMD_STOP 3'h4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define IBT_RST_CNT 16'h0000
`define IBT_RST_RATE_CNT 6'h00

`endif

// ==== verilog/ibt_input_filter.v ====
// Synchroniser and sampled qualification filter for SCL and SDA
`timescale 1ns/1ps
`default_nettype none
`include "ibt_defs.vh"

module ibt_input_filter (
  // Clock, reset, freeze
  input wire clk,
  input wire rstn,
  input wire ce,
  // Filter sampling rate
  input wire [`IBT_RATE_W-1:0] filterSampleRate,
  // Raw bus levels
  input wire sclPin,
  input wire sdaPin,
  // Qualified bus levels
  output reg sclQual,
  output reg sdaQual
);

  reg [1:0] sclSync_r;
  reg [1:0] sdaSync_r;
  reg [`IBT_RATE_W-1:0] rateCnt_r;
  reg [1:0] sclSmp_r;
  reg [1:0] sdaSmp_r;
  wire sampleTick;
  wire [`IBT_RATE_W-1:0] rateTop;

  // ----------------------------------------------------------------
  // Two-stage synchronisers, first stage read only by the second
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sclSync_r <= 2'h3;
      sdaSync_r <= 2'h3;
    end
    else if (ce)
    begin
      sclSync_r <= {sclSync_r[0], sclPin};
      sdaSync_r <= {sdaSync_r[0], sdaPin};
    end
  end

  // Sampling clock enable: memory clock scaled by the rate setting
  assign rateTop = (filterSampleRate == `IBT_RST_RATE_CNT) ?
                   `IBT_RST_RATE_CNT : filterSampleRate - 6'h01;
  assign sampleTick = (rateCnt_r == rateTop);

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rateCnt_r <= `IBT_RST_RATE_CNT;
    else if (ce)
      rateCnt_r <= sampleTick ? `IBT_RST_RATE_CNT : rateCnt_r + 6'h01;
  end

  // ----------------------------------------------------------------
  // One sample per sampling tick, two in a row must agree, then one memory clock to the
  // output: delay is rate times two plus one cycle
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sclSmp_r <= 2'h3;
      sdaSmp_r <= 2'h3;
      sclQual <= 1'b1;
      sdaQual <= 1'b1;
    end
    else if (ce)
    begin
      if (sampleTick)
      begin
        sclSmp_r <= {sclSmp_r[0], sclSync_r[1]};
        sdaSmp_r <= {sdaSmp_r[0], sdaSync_r[1]};
      end
      // Only a level seen on two samples in a row passes
      if (sclSmp_r[1] == sclSmp_r[0])
        sclQual <= sclSmp_r[1];
      if (sdaSmp_r[1] == sdaSmp_r[0])
        sdaQual <= sdaSmp_r[1];
    end
  end

endmodule
`default_nettype wire

// ==== verilog/ibt_bit_timing.v ====
// Master bit-timing generator for the two-wire serial controller
`timescale 1ns/1ps
`default_nettype none
`include "ibt_defs.vh"

module ibt_bit_timing (
  // Clock, reset, freeze
  input wire clk,
  input wire rstn,
  input wire ce,
  // Configuration
  input wire [`IBT_CODE_W-1:0] sclDividerCode,
  input wire [`IBT_RATE_W-1:0] filterSampleRate,
  // Command port
  input wire cmdValid,
  input wire [`IBT_CMD_W-1:0] cmdCode,
  input wire cmdData,
  output wire cmdReady,
  output reg cmdDone,
  output reg rxBit,
  output wire busy,
  output reg [`IBT_DIV_W-1:0] decimalDividerValue,
  // Open-drain bus pins
  input wire sclIn,
  output wire sclOut,
  output reg sclOe,
  input wire sdaIn,
  output wire sdaOut,
  output reg sdaOe
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [`IBT_ST_W-1:0] ST_IDLE = 3'h0;
  localparam [`IBT_ST_W-1:0] ST_START_HOLD = 3'h1;
  localparam [`IBT_ST_W-1:0] ST_PARK = 3'h2;
  localparam [`IBT_ST_W-1:0] ST_LOW = 3'h3;
  localparam [`IBT_ST_W-1:0] ST_HIGH = 3'h4;
  localparam [`IBT_ST_W-1:0] ST_FREE = 3'h5;

  // ----------------------------------------------------------------
  // Code decoding
  // ----------------------------------------------------------------
  // Decimal divider for a code
  function [`IBT_DIV_W-1:0] divOf;
    input [`IBT_CODE_W-1:0] code;
    reg [`IBT_DIV_W-1:0] b;
    begin
      b = 16'h0000;
      divOf = 16'h0000;
      if (!code[`IBT_CODE_BANK])
      begin
        case (code[1:0])
          2'h0: b = 16'h0120;
          2'h1: b = 16'h0140;
          2'h2: b = 16'h0180;
          default: b = 16'h01C0;
        endcase
        if (code[4:0] == 5'h1F)
          divOf = 16'hF000;
        else
          divOf = b << code[4:2];
      end
      else if (code[4:2] == 3'h0)
      begin
        case (code[1:0])
          2'h0: divOf = 16'h00A0;
          2'h1: divOf = 16'h00C0;
          2'h2: divOf = 16'h00E0;
          default: divOf = 16'h0100;
        endcase
      end
      else
      begin
        case (code[1:0])
          2'h0: b = 16'h0140;
          2'h1: b = 16'h0180;
          2'h2: b = 16'h01E0;
          default: b = 16'h0200;
        endcase
        divOf = b << (code[4:2] - 3'h1);
      end
    end
  endfunction

  // Start hold: divider/16 halved until under the bank's limit
  function [`IBT_CNT_W-1:0] startHoldOf;
    input [`IBT_CODE_W-1:0] code;
    input [`IBT_DIV_W-1:0] d;
    reg [`IBT_CNT_W-1:0] q, lim;
    integer i;
    begin
      q = d >> 4;
      lim = code[`IBT_CODE_BANK] ? `IBT_START_LIMIT_HI : `IBT_START_LIMIT_LO;
      for (i = 0; i < `IBT_HALVE_STEPS; i = i + 1)
        if (q >= lim)
          q = q >> 1;
      startHoldOf = (q == 16'h0000) ? 16'h0001 : q;
    end
  endfunction

  // Output data hold time for a code
  function [`IBT_CNT_W-1:0] holdOf;
    input [`IBT_CODE_W-1:0] code;
    reg [`IBT_CNT_W-1:0] step, f;
    begin
      step = `IBT_HOLD_STEP << code[4:2];
      case ({code[`IBT_CODE_BANK], code[`IBT_CODE_SEL]})
        2'h2: f = step;
        2'h3: f = step << 1;
        2'h0: f = (step << 1) + step;
        default: f = step << 2;
      endcase
      holdOf = `IBT_HOLD_BASE + f;
    end
  endfunction

  // ----------------------------------------------------------------
  // Registered timing figures, recomputed from the code each cycle
  // ----------------------------------------------------------------
  reg [`IBT_CNT_W-1:0] half_r, hold_r, startHold_r, rsSetup_r;
  wire [`IBT_DIV_W-1:0] divNow;
  wire [`IBT_CNT_W-1:0] halfNow, holdNow, shNow;

  assign divNow = divOf(sclDividerCode);
  assign halfNow = divNow >> 1;
  assign shNow = startHoldOf(sclDividerCode, divNow);
  // Keep the SDA change no later than the edge that releases SCL in the low half
  assign holdNow = (holdOf(sclDividerCode) >= halfNow) ?
                   halfNow - 16'h0001 : holdOf(sclDividerCode);

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      decimalDividerValue <= `IBT_RST_CNT;
      half_r <= `IBT_RST_CNT;
      hold_r <= `IBT_RST_CNT;
      startHold_r <= `IBT_RST_CNT;
      rsSetup_r <= `IBT_RST_CNT;
    end
    else if (ce)
    begin
      decimalDividerValue <= divNow;
      half_r <= halfNow;
      hold_r <= holdNow;
      startHold_r <= shNow;
      rsSetup_r <= divNow + shNow;
    end
  end

  // ----------------------------------------------------------------
  // Qualified bus inputs
  // ----------------------------------------------------------------
  wire sclQual, sdaQual;

  ibt_input_filter ibt_input_filter_i (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .filterSampleRate(filterSampleRate),
    .sclPin(sclIn),
    .sdaPin(sdaIn),
    .sclQual(sclQual),
    .sdaQual(sdaQual)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  reg [`IBT_ST_W-1:0] state_r;
  reg [`IBT_CNT_W-1:0] cnt_r, highLen;
  reg [`IBT_CMD_W-1:0] op_r;
  reg data_r;
  wire cmdTake;

  // Open-drain: the pin value is always low, only the enable moves
  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;

  assign cmdReady = ce && (((state_r == ST_IDLE) &&
                    (cmdCode == `IBT_CMD_START)) ||
                    ((state_r == ST_PARK) &&
                    (cmdCode != `IBT_CMD_START) &&
                    (cmdCode <= `IBT_CMD_STOP)));
  assign cmdTake = cmdValid && cmdReady;
  assign busy = (state_r != ST_IDLE);

  // Length of the SCL-high phase for the operation in flight
  always @*
  begin
    case (op_r)
      `IBT_CMD_RSTART: highLen = rsSetup_r;
      `IBT_CMD_STOP: highLen = `IBT_STOP_SETUP_CLKS;
      default: highLen = half_r;
    endcase
  end

  // Main state machine
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r <= ST_IDLE;
      cnt_r <= `IBT_RST_CNT;
      op_r <= `IBT_CMD_START;
      data_r <= 1'b1;
      sclOe <= 1'b0;
      sdaOe <= 1'b0;
      cmdDone <= 1'b0;
      rxBit <= 1'b0;
    end
    else if (ce)
    begin
      cmdDone <= 1'b0;
      case (state_r)
        ST_IDLE:
        begin
          cnt_r <= `IBT_RST_CNT;
          if (cmdTake)
          begin
            op_r <= cmdCode;
            sdaOe <= 1'b1; // SDA falls with SCL released
            state_r <= ST_START_HOLD;
          end
        end
        ST_START_HOLD:
        begin
          // Hold the start before pulling SCL low
          if (cnt_r >= startHold_r - 16'h0001)
          begin
            sclOe <= 1'b1;
            cnt_r <= `IBT_RST_CNT;
            cmdDone <= 1'b1;
            state_r <= ST_PARK;
          end
          else
            cnt_r <= cnt_r + 16'h0001;
        end
        ST_PARK:
        begin
          cnt_r <= `IBT_RST_CNT;
          if (cmdTake)
          begin
            op_r <= cmdCode;
            data_r <= cmdData;
            state_r <= ST_LOW;
          end
        end
        ST_LOW:
        begin
          // SDA moves once the hold time has passed
          if (cnt_r == hold_r)
          begin
            case (op_r)
              `IBT_CMD_WRITE: sdaOe <= ~data_r;
              `IBT_CMD_STOP: sdaOe <= 1'b1;
              default: sdaOe <= 1'b0;
            endcase
          end
          // Remaining low time is the data setup
          if (cnt_r >= half_r - 16'h0001)
          begin
            sclOe <= 1'b0;
            cnt_r <= `IBT_RST_CNT;
            state_r <= ST_HIGH;
          end
          else
            cnt_r <= cnt_r + 16'h0001;
        end
        ST_HIGH:
        begin
          // Count only once the qualified SCL is seen high
          if (!sclQual)
            cnt_r <= `IBT_RST_CNT;
          else if (cnt_r >= highLen - 16'h0001)
          begin
            cnt_r <= `IBT_RST_CNT;
            case (op_r)
              `IBT_CMD_RSTART:
              begin
                sdaOe <= 1'b1;
                state_r <= ST_START_HOLD;
              end
              `IBT_CMD_STOP:
              begin
                sdaOe <= 1'b0;
                state_r <= ST_FREE;
              end
              default:
              begin
                rxBit <= sdaQual;
                sclOe <= 1'b1;
                cmdDone <= 1'b1;
                state_r <= ST_PARK;
              end
            endcase
          end
          else
            cnt_r <= cnt_r + 16'h0001;
        end
        ST_FREE:
        begin
          // Bus-free time after a stop
          if (cnt_r >= half_r - 16'h0001)
          begin
            cnt_r <= `IBT_RST_CNT;
            cmdDone <= 1'b1;
            state_r <= ST_IDLE;
          end
          else
            cnt_r <= cnt_r + 16'h0001;
        end
        default:
        begin
          sclOe <= 1'b0;
          sdaOe <= 1'b0;
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ==== tb/ibt_bus_model.sv ====
// Far-side bus model: clock stretching, acknowledge and pull-ups
`timescale 1ns/1ps
`default_nettype none
module ibt_bus_model (
  // Clock
  input wire logic clk,
  // Behaviour chosen by the bench
  input wire logic [7:0] stretchLen,
  input wire logic ackLow,
  // Controller pull-downs
  input wire logic sclOe,
  input wire logic sdaOe,
  // Resolved line levels
  output logic sclIn,
  output logic sdaIn
);
  logic [7:0] holdCnt_r = 8'h00;
  // Hold SCL low a while after the controller lets go
  always @(posedge clk)
    if (sclOe)
      holdCnt_r <= stretchLen;
    else if (holdCnt_r != 8'h00)
      holdCnt_r <= holdCnt_r - 8'h01;
  // Wired-AND, released lines float up to the pull-ups
  assign sclIn = ~(sclOe | (holdCnt_r != 8'h00));
  assign sdaIn = ~(sdaOe | ackLow);
endmodule
`default_nettype wire

// ==== tb/ibt_bit_timing_chk.sv ====
// Port checker for the bit-timing generator
`timescale 1ns/1ps
`default_nettype none
`include "ibt_defs.vh"
module ibt_bit_timing_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // Configuration and command port
  input wire logic [5:0] sclDividerCode,
  input wire logic [2:0] cmdCode,
  input wire logic cmdValid,
  input wire logic cmdReady,
  input wire logic cmdDone,
  input wire logic busy,
  input wire logic [15:0] decimalDividerValue,
  // Bus pins
  input wire logic sclIn,
  input wire logic sclOut,
  input wire logic sclOe,
  input wire logic sdaOut,
  input wire logic sdaOe
);
  logic [15:0] lowCnt_r;
  logic [15:0] sdaCnt_r;
  logic sdaPrev_r;
  logic fast;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Code 0x20: divider 160, start hold 5, data hold 24
  assign fast = sclDividerCode == 6'h20;
  // Cycles SCL has been pulled low, and since SDA last moved
  always @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      lowCnt_r <= 16'h0000;
      sdaCnt_r <= 16'h0000;
      sdaPrev_r <= 1'b0;
    end
    else
    begin
      lowCnt_r <= sclOe ? lowCnt_r + 16'h0001 : 16'h0000;
      sdaCnt_r <= (sdaOe != sdaPrev_r) ? 16'h0000 : sdaCnt_r + 16'h0001;
      sdaPrev_r <= sdaOe;
    end
  property p_drain; sclOut == 1'b0 && sdaOut == 1'b0; endproperty
  a_drain: assert property (p_drain)
    else $error("pin driven high");
  property p_div_a;
    $stable(sclDividerCode) && fast |=> decimalDividerValue == 16'h00A0;
  endproperty
  a_div_a: assert property (p_div_a)
    else $error("divider for 0x20 wrong");
  property p_div_b; $stable(sclDividerCode) && sclDividerCode == 6'h1F
    |=> decimalDividerValue == 16'hF000; endproperty
  a_div_b: assert property (p_div_b)
    else $error("divider for 0x1F wrong");
  property p_start; cmdValid && cmdReady && cmdCode == `IBT_CMD_START
    && fast |=> !cmdDone [*4] ##[1:3] cmdDone; endproperty
  a_start: assert property (p_start)
    else $error("start hold length wrong");
  property p_low; $fell(sclOe) && fast |-> lowCnt_r >= 16'h004F; endproperty
  a_low: assert property (p_low)
    else $error("SCL low too short");
  property p_hold; $changed(sdaOe) && sclOe && $past(sclOe) && fast
    |-> lowCnt_r >= 16'h0016; endproperty
  a_hold: assert property (p_hold)
    else $error("data hold too short");
  property p_setup; $fell(sclOe) && fast |-> sdaCnt_r >= 16'h0032; endproperty
  a_setup: assert property (p_setup)
    else $error("data setup too short");
  property p_stop; $fell(sdaOe) && !sclOe |-> $past(sclIn, 4); endproperty
  a_stop: assert property (p_stop)
    else $error("stop setup too short");
  property p_pulse; cmdDone |=> !cmdDone; endproperty
  a_pulse: assert property (p_pulse)
    else $error("done longer than one cycle");
  property p_idle;
    !busy |-> cmdReady == (ce && cmdCode == `IBT_CMD_START);
  endproperty
  a_idle: assert property (p_idle)
    else $error("ready wrong while idle");
  c_start: cover property (cmdReady && cmdValid && cmdCode == 3'h0);
  c_rstart: cover property (cmdReady && cmdValid && cmdCode == 3'h3);
  c_stop: cover property (cmdReady && cmdValid && cmdCode == 3'h4);
endmodule
bind ibt_bit_timing ibt_bit_timing_chk ibt_bit_timing_chk_i (
  .clk(clk), .rstn(rstn), .ce(ce), .sclDividerCode(sclDividerCode),
  .cmdCode(cmdCode), .cmdValid(cmdValid), .cmdReady(cmdReady),
  .cmdDone(cmdDone), .busy(busy), .sclIn(sclIn),
  .decimalDividerValue(decimalDividerValue), .sclOut(sclOut),
  .sclOe(sclOe), .sdaOut(sdaOut), .sdaOe(sdaOe));
`default_nettype wire

// ==== tb/ibt_bit_timing_bench.sv ====
// Self-checking bench for the bit-timing generator
`timescale 1ns/1ps
`default_nettype none
`include "ibt_defs.vh"
module ibt_bit_timing_bench;
  logic clk, rstn, ce, cmdValid, cmdData, ackLow;
  logic [5:0] code, rate;
  logic [2:0] cmdCode;
  logic [7:0] stretch;
  wire logic cmdReady, cmdDone, rxBit, busy, sclOut, sclOe, sdaOut, sdaOe;
  wire logic sclIn, sdaIn;
  wire logic [15:0] divVal;
  int errCount = 0;
  int testsRun = 0;
  int cycles = 0;
  ibt_bit_timing ibt_bit_timing_i (.clk(clk), .rstn(rstn), .ce(ce),
    .sclDividerCode(code), .filterSampleRate(rate), .cmdValid(cmdValid),
    .cmdCode(cmdCode), .cmdData(cmdData), .cmdReady(cmdReady),
    .cmdDone(cmdDone), .rxBit(rxBit), .busy(busy),
    .decimalDividerValue(divVal), .sclIn(sclIn), .sclOut(sclOut),
    .sclOe(sclOe), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe));
  ibt_bus_model ibt_bus_model_i (.clk(clk), .stretchLen(stretch),
    .ackLow(ackLow), .sclOe(sclOe), .sdaOe(sdaOe), .sclIn(sclIn),
    .sdaIn(sdaIn));
  // Clock, 50 ns period
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Cut a hung run short
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      errCount = errCount + 1;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    testsRun++;
    if (got !== exp)
    begin
      errCount++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic inRange(input int got, input int lo, input int hi);
    testsRun++;
    if (got < lo || got > hi)
    begin
      errCount++;
      $display("ERROR %0t count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask
  // One command: hold the request until taken, count cycles to done
  task automatic issue(input logic [2:0] c, input logic d, output int n);
    n = 0;
    @(posedge clk);
    cmdValid <= 1'b1;
    cmdCode <= c;
    cmdData <= d;
    @(negedge clk);
    while (cmdReady !== 1'b1) @(negedge clk);
    @(posedge clk);
    cmdValid <= 1'b0;
    do
    begin
      @(negedge clk);
      n++;
    end while (cmdDone !== 1'b1 && n < 1000);
  endtask
  // Decoded dividers, including codes sharing an input rate
  task automatic t_decode();
    logic [5:0] cs [10] = '{6'h20, 6'h21, 6'h00, 6'h01, 6'h1E, 6'h1F,
      6'h22, 6'h23, 6'h24, 6'h25};
    logic [15:0] ds [10] = '{16'h00A0, 16'h00C0, 16'h0120, 16'h0140,
      16'hC000, 16'hF000, 16'h00E0, 16'h0100, 16'h0140, 16'h0180};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clk);
      code <= cs[i];
      repeat (2) @(posedge clk);
      @(negedge clk);
      cmp(divVal, ds[i]);
    end
    @(posedge clk);
    code <= 6'h20;
    $display("decode test done");
  endtask
  // A bit command from idle is refused
  task automatic t_refuse();
    @(posedge clk);
    cmdCode <= `IBT_CMD_WRITE;
    cmdValid <= 1'b1;
    @(negedge clk);
    cmp(16'(cmdReady), 16'h0000);
    @(posedge clk);
    cmdValid <= 1'b0;
    @(negedge clk);
    cmp(16'(busy), 16'h0000);
    // Frozen by the clock enable, even a start is refused
    @(posedge clk);
    ce <= 1'b0;
    cmdCode <= `IBT_CMD_START;
    cmdValid <= 1'b1;
    repeat (3) @(negedge clk);
    cmp(16'(cmdReady), 16'h0000);
    @(posedge clk);
    ce <= 1'b1;
    cmdValid <= 1'b0;
    @(negedge clk);
    cmp(16'(busy), 16'h0000);
    $display("refuse test done");
  endtask
  // Start, plain and stretched writes, acknowledged and released reads
  task automatic t_bits();
    int n;
    int n1;
    issue(`IBT_CMD_START, 1'b0, n);
    inRange(n, 4, 6);
    issue(`IBT_CMD_WRITE, 1'b1, n1);
    inRange(n1, 160, 185);
    cmp(16'(rxBit), 16'h0001);
    @(posedge clk);
    stretch <= 8'h28;
    issue(`IBT_CMD_WRITE, 1'b0, n);
    inRange(n - n1, 36, 44);
    cmp(16'(rxBit), 16'h0000);
    @(posedge clk);
    stretch <= 8'h00;
    ackLow <= 1'b1;
    issue(`IBT_CMD_READ, 1'b1, n);
    inRange(n, 160, 185);
    cmp(16'(rxBit), 16'h0000);
    @(posedge clk);
    ackLow <= 1'b0;
    issue(`IBT_CMD_READ, 1'b1, n);
    inRange(n, 160, 185);
    cmp(16'(rxBit), 16'h0001);
    $display("bit test done");
  endtask
  // Repeated start, then stop back to an idle released bus
  task automatic t_end();
    int n;
    issue(`IBT_CMD_RSTART, 1'b0, n);
    inRange(n, 250, 290);
    issue(`IBT_CMD_STOP, 1'b0, n);
    inRange(n, 164, 190);
    @(negedge clk);
    cmp(16'(busy), 16'h0000);
    cmp(16'(sdaIn & sclIn), 16'h0001);
    $display("end test done");
  endtask
  // Main sequence
  initial
  begin
    rstn = 1'b0;
    ce = 1'b1;
    cmdValid = 1'b0;
    cmdData = 1'b0;
    cmdCode = 3'h0;
    code = 6'h20;
    rate = 6'h02;
    stretch = 8'h00;
    ackLow = 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    t_decode();
    t_refuse();
    t_bits();
    t_end();
    wrap_up();
  end
endmodule
`default_nettype wire
